// file: include/sar_regs.vh
// Register map, field positions, reset values and bus constants of the alert responder
`ifndef SAR_REGS_VH
`define SAR_REGS_VH
`define SAR_ADDR_W        8
`define SAR_A_FLAGS       8'h00
`define SAR_A_WD_EN       8'h04
`define SAR_A_IRQ_MASK    8'h08
`define SAR_IDX_ALERT_CFG 8'h03
`define SAR_A_ALERT_CFG   8'h0C
`define SAR_A_GPIO        8'h10
`define SAR_A_IRQ_STAT    8'h14
`define SAR_A_OWN_ADDR    8'h18
`define SAR_NUM_WD        8
`define SAR_FLAG_ALERT    8
`define SAR_CFG_LATCH     0
`define SAR_CFG_ENABLE    1
`define SAR_IRQ_W         3
`define SAR_IRQ_ALERT     0
`define SAR_IRQ_ARA_DONE  1
`define SAR_IRQ_ARA_LOST  2
`define SAR_RST_WD_EN     8'h00
`define SAR_RST_CFG       2'h0
`define SAR_RST_MASK      3'h0
`define SAR_RST_OWN_ADDR  7'h00
`define SAR_ARA_RD_BYTE   8'h19
`define SAR_BIT_LAST      3'h7
`define SAR_ST_IDLE       3'h0
`define SAR_ST_ADDR       3'h1
`define SAR_ST_ADDR_ACK   3'h2
`define SAR_ST_ACK        3'h3
`define SAR_ST_TX         3'h4
`define SAR_ST_TX_END     3'h5
`endif

// file: rtl/sar_ara_resp.v
// Two-wire alert response address responder with arbitration
`timescale 1ns/1ps
`include "sar_regs.vh"
module sar_ara_resp (
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  input  wire       scl_i,
  input  wire       sda_i,
  input  wire       arm_i,
  input  wire [6:0] own_addr_i,
  output reg        sda_oe_o,
  output reg        done_o,
  output reg        lost_o
);
  localparam [2:0] ST_IDLE = `SAR_ST_IDLE;
  localparam [2:0] ST_ADDR = `SAR_ST_ADDR;
  localparam [2:0] ST_AACK = `SAR_ST_ADDR_ACK;
  localparam [2:0] ST_ACK  = `SAR_ST_ACK;
  localparam [2:0] ST_TX   = `SAR_ST_TX;
  localparam [2:0] ST_TEND = `SAR_ST_TX_END;

  reg [2:0] state_r;
  reg [2:0] cnt_r;
  reg [7:0] sh_r;
  reg       scl_q_r;
  reg       sda_q_r;
  reg       match_r;
  wire      scl_rise = scl_i & ~scl_q_r;
  wire      scl_fall = ~scl_i & scl_q_r;
  wire      start_c  = scl_i & scl_q_r & sda_q_r & ~sda_i;
  wire      stop_c   = scl_i & scl_q_r & ~sda_q_r & sda_i;

  // Bit engine; start and stop conditions override any state
  always @(posedge sys_clk_i) begin
    done_o <= 1'b0;
    lost_o <= 1'b0;
    if (!rst_n_i) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 3'h0;
      sh_r     <= 8'h00;
      scl_q_r  <= 1'b1;
      sda_q_r  <= 1'b1;
      match_r  <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
      if (start_c) begin
        state_r  <= ST_ADDR;
        cnt_r    <= 3'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        state_r  <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR: if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_i};
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == `SAR_BIT_LAST) begin
              match_r <= ({sh_r[6:0], sda_i} == `SAR_ARA_RD_BYTE);
              state_r <= ST_AACK;
            end
          end
          // Only a pending latched alert answers the broadcast
          ST_AACK: if (scl_fall) begin
            if (match_r && arm_i) begin
              sda_oe_o <= 1'b1;
              state_r  <= ST_ACK;
            end else begin
              state_r <= ST_IDLE;
            end
          end
          // Present own address, low bit released as a one
          ST_ACK: if (scl_fall) begin
            sh_r     <= {own_addr_i, 1'b1};
            sda_oe_o <= ~own_addr_i[6];
            cnt_r    <= 3'h0;
            state_r  <= ST_TX;
          end
          ST_TX: begin
            if (scl_rise) begin
              // Released one seen low: a lower address wins, we back off
              if (sh_r[7] && !sda_i) begin
                sda_oe_o <= 1'b0;
                lost_o   <= 1'b1;
                state_r  <= ST_IDLE;
              end else begin
                sh_r  <= {sh_r[6:0], 1'b1};
                cnt_r <= cnt_r + 3'h1;
                if (cnt_r == `SAR_BIT_LAST)
                  state_r <= ST_TEND;
              end
            end else if (scl_fall) begin
              sda_oe_o <= ~sh_r[7];
            end
          end
          // Whole byte sent unchallenged: the response succeeded
          ST_TEND: if (scl_fall) begin
            sda_oe_o <= 1'b0;
            done_o   <= 1'b1;
            state_r  <= ST_IDLE;
          end
          default: begin
            state_r  <= ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// file: rtl/sar_alert.v
// Latched alert, status flags, alert response and GPIO behind a Wishbone slave
//
// Overview of operation
// - Alert response answered only when alert enabled and latch mode bit 0 set.
// - Latched alert held until status read or successful alert response; the code also releases it when the alert function is disabled.
// - Alert re-asserts after clearing if the fault is still present.
// - Alert assertion never stops conversions already running.
// - Alert pin is open-drain: pull low or release only.
// - Pending device answers with its own slave address.
// - Simultaneous responders arbitrate; lower address code wins.
// - Arbitration loser does not acknowledge and keeps alert low.
// - Alert flag cleared by status read or disabling alert function.
// - Status flags report tripped watchdogs; all zero after reset.
// - Software GPIO drives an external bus-voltage measurement switch.
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sar_regs.vh"
module sar_alert (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [7:0]  wd_trip_i,
  input  wire        conv_busy_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output wire        sda_oe_o,
  output reg         alert_n_o,
  output reg         alert_n_oe_o,
  output reg         gpio_o,
  output reg         conv_busy_o,
  output reg         irq_o
);
  reg  [7:0] wd_en_r;
  reg  [7:0] flags_r;
  reg        alert_flag_r;
  reg        alert_pin_r;
  reg  [1:0] cfg_r;
  reg  [2:0] irq_mask_r;
  reg  [2:0] irq_stat_r;
  reg  [6:0] own_addr_r;
  reg  [7:0] flags_nxt;
  reg        alert_flag_nxt;
  reg        alert_pin_nxt;
  reg  [2:0] irq_stat_nxt;
  reg  [31:0] rd_nxt;
  wire [7:0] trip_en;
  wire       ara_done;
  wire       ara_lost;
  wire       bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr_en    = bus_req & wb_we_i & wb_sel_i[0];
  wire       rd_flags = bus_req & ~wb_we_i & (wb_adr_i == `SAR_A_FLAGS);
  wire       rd_irq   = bus_req & ~wb_we_i & (wb_adr_i == `SAR_A_IRQ_STAT);
  wire       latch_md = cfg_r[`SAR_CFG_LATCH];
  wire       alert_en = cfg_r[`SAR_CFG_ENABLE];
  wire       fault    = |trip_en;
  wire       cfg_off  = wr_en & (wb_adr_i == `SAR_A_ALERT_CFG) & ~wb_dat_i[`SAR_CFG_ENABLE];

  // Per-watchdog gating of the raw trip levels
  genvar g;
  generate
    for (g = 0; g < `SAR_NUM_WD; g = g + 1) begin : g_wd
      assign trip_en[g] = wd_trip_i[g] & wd_en_r[g];
    end
  endgenerate

  // Sticky flags: a trip in the same cycle as the clearing read survives
  always @* begin
    flags_nxt = flags_r;
    if (rd_flags)
      flags_nxt = 8'h00;
    flags_nxt = flags_nxt | trip_en;
  end

  // Internal alert flag has its own clear path, apart from the pin
  always @* begin
    alert_flag_nxt = alert_flag_r;
    if (rd_flags || cfg_off || !alert_en)
      alert_flag_nxt = 1'b0;
    if (alert_en && fault)
      alert_flag_nxt = 1'b1;
  end

  // Pin latch: a status read, a won response or disabling the alert releases it
  always @* begin
    alert_pin_nxt = alert_pin_r;
    if (rd_flags || ara_done)
      alert_pin_nxt = 1'b0;
    if (!alert_en)
      alert_pin_nxt = 1'b0;
    else if (!latch_md)
      alert_pin_nxt = fault;
    else if (fault)
      alert_pin_nxt = 1'b1;
  end

  // Interrupt events: alert rising, response won, response lost
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (rd_irq)
      irq_stat_nxt = `SAR_RST_MASK;
    if (alert_pin_nxt && !alert_pin_r)
      irq_stat_nxt[`SAR_IRQ_ALERT] = 1'b1;
    if (ara_done)
      irq_stat_nxt[`SAR_IRQ_ARA_DONE] = 1'b1;
    if (ara_lost)
      irq_stat_nxt[`SAR_IRQ_ARA_LOST] = 1'b1;
  end

  // Read mux; unmapped offsets read zero and still acknowledge
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `SAR_A_FLAGS:     rd_nxt = {23'h000000, alert_flag_r, flags_r};
      `SAR_A_WD_EN:     rd_nxt = {24'h000000, wd_en_r};
      `SAR_A_IRQ_MASK:  rd_nxt = {29'h00000000, irq_mask_r};
      `SAR_A_ALERT_CFG: rd_nxt = {30'h00000000, cfg_r};
      `SAR_A_GPIO:      rd_nxt = {31'h00000000, gpio_o};
      `SAR_A_IRQ_STAT:  rd_nxt = {29'h00000000, irq_stat_r};
      `SAR_A_OWN_ADDR:  rd_nxt = {25'h0000000, own_addr_r};
      default:          rd_nxt = 32'h0000_0000;
    endcase
  end

  // Wishbone slave: one wait state, ack for one cycle
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_nxt : 32'h0000_0000;
    end
  end

  // Software-written controls
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wd_en_r    <= `SAR_RST_WD_EN;
      cfg_r      <= `SAR_RST_CFG;
      irq_mask_r <= `SAR_RST_MASK;
      own_addr_r <= `SAR_RST_OWN_ADDR;
      gpio_o     <= 1'b0;
    end else if (wr_en) begin
      case (wb_adr_i)
        `SAR_A_WD_EN:     wd_en_r    <= wb_dat_i[7:0];
        `SAR_A_ALERT_CFG: cfg_r      <= wb_dat_i[1:0];
        `SAR_A_IRQ_MASK:  irq_mask_r <= wb_dat_i[2:0];
        `SAR_A_OWN_ADDR:  own_addr_r <= wb_dat_i[6:0];
        `SAR_A_GPIO:      gpio_o     <= wb_dat_i[0];
        default:          gpio_o     <= gpio_o;
      endcase
    end
  end

  // Alert state and pins
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      flags_r      <= 8'h00;
      alert_flag_r <= 1'b0;
      alert_pin_r  <= 1'b0;
      irq_stat_r   <= `SAR_RST_MASK;
      irq_o        <= 1'b0;
      alert_n_o    <= 1'b0;
      alert_n_oe_o <= 1'b0;
      sda_o        <= 1'b0;
      conv_busy_o  <= 1'b0;
    end else begin
      flags_r      <= flags_nxt;
      alert_flag_r <= alert_flag_nxt;
      alert_pin_r  <= alert_pin_nxt;
      irq_stat_r   <= irq_stat_nxt;
      irq_o        <= |(irq_stat_nxt & irq_mask_r);
      // Open drain: data stays low, only the enable moves
      alert_n_o    <= 1'b0;
      alert_n_oe_o <= alert_pin_nxt;
      sda_o        <= 1'b0;
      // Conversion status passes straight on; alert never gates it
      conv_busy_o  <= conv_busy_i;
    end
  end

  // Responder is armed only for a pending latched alert
  sar_ara_resp u_ara (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .arm_i      (alert_en & latch_md & alert_pin_r),
    .own_addr_i (own_addr_r),
    .sda_oe_o   (sda_oe_o),
    .done_o     (ara_done),
    .lost_o     (ara_lost)
  );
endmodule

// file: test/sar_host_mdl.sv
// Two-wire host and a rival alerting slave sharing the bus with the responder
`timescale 1ns/1ps
module sar_host_mdl (
  input  logic sys_clk_i,
  input  logic dut_oe_i,
  output logic scl_o,
  output logic sda_o
);
  localparam logic [7:0] ARA_RD = 8'h19;
  logic scl_r = 1'b1;
  logic hst_r = 1'b1;
  logic riv_r = 1'b1;
  // Pulled-up wires: SCL idles high between frames, SDA is a wired AND
  assign scl_o = scl_r;
  assign sda_o = hst_r & riv_r & ~dut_oe_i;
  // One bit: data moves a cycle after SCL falls, sampled mid high phase
  task automatic slot(input logic hb, input logic rb, output logic s);
    @(posedge sys_clk_i);
    hst_r <= hb;
    riv_r <= rb;
    repeat (4) @(posedge sys_clk_i);
    scl_r <= 1'h1;
    repeat (2) @(posedge sys_clk_i);
    s = sda_o;
    repeat (2) @(posedge sys_clk_i);
    scl_r <= 1'h0;
  endtask
  // Alert response read; rival byte 8'hFF means no rival is alerting
  task automatic ara(input logic [7:0] rival, output logic ack, output logic [7:0] got);
    logic s;
    logic lost;
    lost = 1'b0;
    hst_r <= 1'h0;
    repeat (4) @(posedge sys_clk_i);
    scl_r <= 1'h0;
    for (int i = 7; i >= 0; i--) slot(ARA_RD[i], 1'h1, s);
    slot(1'h1, 1'h1, s);
    ack = !s;
    // Rival backs off once it reads a 0 against its own 1
    for (int i = 7; i >= 0; i--) begin
      slot(1'h1, rival[i] | lost, s);
      lost = lost | (rival[i] & !s);
      got[i] = s;
    end
    slot(1'h1, 1'h1, s);
    @(posedge sys_clk_i);
    hst_r <= 1'h0;
    repeat (4) @(posedge sys_clk_i);
    scl_r <= 1'h1;
    repeat (4) @(posedge sys_clk_i);
    hst_r <= 1'h1;
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule

// file: test/sar_alert_chk.sv
// Port-level assertions for the alert responder
`timescale 1ns/1ps
`include "sar_regs.vh"
module sar_alert_chk (
  input logic        sys_clk_i,
  input logic        rst_n_i,
  input logic        wb_we_i,
  input logic [7:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic        wb_ack_o,
  input logic [7:0]  wd_trip_i,
  input logic        conv_busy_i,
  input logic        scl_i,
  input logic        sda_i,
  input logic        sda_o,
  input logic        sda_oe_o,
  input logic        alert_n_o,
  input logic        alert_n_oe_o,
  input logic        gpio_o,
  input logic        conv_busy_o,
  input logic        irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Status read seen while its acknowledge is out
  wire flag_rd = wb_ack_o && !wb_we_i && wb_adr_i == `SAR_A_FLAGS;
  drive_low_a: assert property (!sda_o && !alert_n_o)
    else $error("open-drain pin driven high");
  conv_pass_a: assert property ($past(rst_n_i) |-> conv_busy_o == $past(conv_busy_i))
    else $error("conversion busy disturbed");
  alert_cause_a: assert property ($rose(alert_n_oe_o) |->
    $past(wd_trip_i) != 8'h00 || $past(wd_trip_i, 2) != 8'h00)
    else $error("alert without trip");
  ara_armed_a: assert property ($rose(sda_oe_o) |-> $past(alert_n_oe_o))
    else $error("answered with no alert");
  lose_hold_a: assert property ($rose(scl_i) && !sda_oe_o && !sda_i && alert_n_oe_o
    |=> (!sda_oe_o && alert_n_oe_o) [*3])
    else $error("loser drove bus or dropped alert");
  gpio_wr_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == `SAR_A_GPIO
    && wb_sel_i[0] |-> gpio_o == wb_dat_i[0])
    else $error("gpio not written");
  rst_quiet_a: assert property ($rose(rst_n_i) |-> !alert_n_oe_o && !irq_o)
    else $error("outputs active after reset");
  flag_clr_a: assert property (flag_rd && wd_trip_i == 8'h00
    && $past(wd_trip_i) == 8'h00 |=> ##1 !alert_n_oe_o)
    else $error("alert kept after status read");
  re_assert_a: assert property (flag_rd && alert_n_oe_o && $stable(wd_trip_i)
    && wd_trip_i != 8'h00 |-> ##3 alert_n_oe_o)
    else $error("alert not re-asserted");
endmodule
bind sar_alert sar_alert_chk u_chk (.sys_clk_i, .rst_n_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .wd_trip_i, .conv_busy_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
  .alert_n_o, .alert_n_oe_o, .gpio_o, .conv_busy_o, .irq_o);

// file: test/sar_alert_tb_top.sv
// Self-checking bench for the alert responder
`timescale 1ns/1ps
`include "sar_regs.vh"
module sar_alert_tb_top;
  logic        sys_clk_i = 1'h0;
  logic        rst_n_i = 1'h0;
  logic        cyc = 1'h0;
  logic        we = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [7:0]  trip = 8'h00;
  logic        busy = 1'h0;
  logic [31:0] rdat;
  logic        ack, scl, sda, dsda, doe, an, aoe, gpio, bsy, irq, hack;
  logic [7:0]  got;
  logic [6:0]  own;
  int          k, n_fail = 0, n_checks = 0;
  // Clock of 4 ns
  always #2 sys_clk_i = ~sys_clk_i;
  sar_alert u_dut (.sys_clk_i, .rst_n_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wd_trip_i(trip), .conv_busy_i(busy), .scl_i(scl), .sda_i(sda), .sda_o(dsda),
    .sda_oe_o(doe), .alert_n_o(an), .alert_n_oe_o(aoe), .gpio_o(gpio),
    .conv_busy_o(bsy), .irq_o(irq));
  sar_host_mdl u_host (.sys_clk_i, .dut_oe_i(doe), .scl_o(scl), .sda_o(sda));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then idle one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    t = 0;
    do begin
      @(posedge sys_clk_i);
      t++;
    end while (ack !== 1'h1 && t < 50);
    r = rdat;
    if (t == 50) begin
      n_fail++;
      $display("[ERR] %0t bus timeout", $time);
      complete_run();
    end
    cyc <= 1'h0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'h0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'h1, a, d, r);
  endtask
  task automatic pause();
    repeat (3) @(posedge sys_clk_i);
  endtask
  // Main sequence
  initial begin
    own = 7'($urandom(79)) | 7'h01;
    k = $urandom % 8;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    @(posedge sys_clk_i);
    rd(`SAR_A_FLAGS, 32'h0);
    rd(`SAR_A_IRQ_STAT, 32'h0);
    rd(8'hFC, 32'h0);
    wr(`SAR_A_WD_EN, 32'hFF);
    wr(`SAR_A_IRQ_MASK, 32'h7);
    wr(`SAR_A_ALERT_CFG, 32'h3);
    wr(`SAR_A_OWN_ADDR, {25'h0, own});
    wr(`SAR_A_GPIO, 32'h1);
    chk(gpio, 1'h1);
    wr(`SAR_A_GPIO, 32'h0);
    chk(gpio, 1'h0);
    $display("registers done");
    trip <= 8'h01 << k;
    busy <= 1'h1;
    pause();
    trip <= 8'h00;
    pause();
    chk({aoe, irq, bsy}, 3'h7);
    rd(`SAR_A_FLAGS, 32'h100 | (32'h1 << k));
    pause();
    chk(aoe, 1'h0);
    rd(`SAR_A_IRQ_STAT, 32'h1);
    chk(irq, 1'h0);
    $display("latch done");
    trip <= 8'h80;
    pause();
    rd(`SAR_A_FLAGS, 32'h180);
    trip <= 8'h00;
    pause();
    chk(aoe, 1'h1);
    u_host.ara(8'hFF, hack, got);
    chk({hack, got}, {1'h1, own, 1'h1});
    pause();
    chk(aoe, 1'h0);
    rd(`SAR_A_IRQ_STAT, 32'h3);
    rd(`SAR_A_FLAGS, 32'h180);
    $display("response done");
    trip <= 8'h80;
    pause();
    trip <= 8'h00;
    u_host.ara({own - 7'h01, 1'h1}, hack, got);
    chk({aoe, got}, {1'h1, own - 7'h01, 1'h1});
    rd(`SAR_A_IRQ_STAT, 32'h5);
    rd(`SAR_A_FLAGS, 32'h180);
    $display("arbitration done");
    wr(`SAR_A_ALERT_CFG, 32'h2);
    trip <= 8'h80;
    pause();
    u_host.ara(8'hFF, hack, got);
    chk({aoe, hack, got}, {2'h2, 8'hFF});
    trip <= 8'h00;
    pause();
    wr(`SAR_A_ALERT_CFG, 32'h0);
    pause();
    chk(aoe, 1'h0);
    rd(`SAR_A_FLAGS, 32'h080);
    $display("mode done");
    complete_run();
  end
endmodule
